// File: design/counter_array.sv
// Counter array: shared time base, control registers and up to five modules.
`timescale 1ns/1ps
`include "counter_array_cfg.svh"
module counter_array
#(
	parameter int NUM_MODULES = 5
)
(
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Special function register access from the core.
	input  wire logic [7:0]   sfr_addr,
	input  wire logic         sfr_wr,
	input  wire logic         sfr_rd,
	input  wire logic [7:0]   sfr_wdata,
	output logic      [7:0]   sfr_rdata,
	// Core status and timer 0.
	input  wire logic         twelve_clock_mode,
	input  wire logic         idle_mode,
	input  wire logic         timer0_overflow,
	// Port 1 pins.
	input  wire logic [7:0]   port1_in,
	output logic      [7:0]   port1_out,
	output logic      [7:0]   port1_oe,
	// Requests to the core.
	output logic              array_irq,
	output logic              watchdog_reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	localparam logic [7:0] CTRL_RST = `CA_CTRL_RST;

	generate
		if (NUM_MODULES < 1 || NUM_MODULES > 5)
		begin : g_bad_count
			$error("NUM_MODULES must lie between 1 and 5");
		end
	endgenerate

	// Control, mode and counter state.
	logic                              overflow_flag_reg;
	logic                              counter_run_reg;
	logic [4:0]                        module_event_flag_reg;
	logic                              idle_halt_reg;
	logic                              watchdog_enable_reg;
	logic                              source_sel_hi_reg;
	logic                              source_sel_lo_reg;
	logic                              overflow_irq_enable_reg;
	counter_array_pkg::count_t         count_reg;
	counter_array_pkg::count_t         count_next;
	logic                              count_moved_reg;
	logic [3:0]                        presc_reg;
	logic [3:0]                        presc_next;
	logic                              ext_prev_reg;
	logic [7:0]                        rdata_next;

	// Decoded strobes and derived events.
	logic                              wr_ctrl;
	logic                              wr_mode;
	logic                              wr_cnt_lo;
	logic                              wr_cnt_hi;
	logic                              cnt_wr;
	counter_array_pkg::count_source_e  source;
	logic                              osc_src;
	logic [3:0]                        div_len;
	logic                              osc_tick;
	logic                              ext_fall;
	logic                              src_event;
	logic                              halted;
	logic                              count_tick;
	logic                              overflow;
	logic                              ovf_next;
	logic [4:0]                        ev_set;
	logic [4:0]                        ev_next;
	logic [4:0]                        irq_en;
	logic [4:0]                        mod_match;
	logic [4:0]                        mod_pin_out;
	logic [4:0]                        mod_pin_oe;
	logic                              irq_next;
	logic                              wd_hit;
	logic [7:0]                        ctrl_rd;
	logic [7:0]                        mode_rd;
	logic [7:0]                        base_rd;
	logic [7:0]                        rd_chain [0:5];

	assign wr_ctrl   = sfr_wr & (sfr_addr == `CA_CTRL_ADDR);
	assign wr_mode   = sfr_wr & (sfr_addr == `CA_MODE_ADDR);
	assign wr_cnt_lo = sfr_wr & (sfr_addr == `CA_CNT_LO_ADDR);
	assign wr_cnt_hi = sfr_wr & (sfr_addr == `CA_CNT_HI_ADDR);
	assign cnt_wr    = wr_cnt_lo | wr_cnt_hi;

	// Source decode and prescaler; the core clock is the oscillator.
	assign source = !source_sel_hi_reg
		? (!source_sel_lo_reg ? counter_array_pkg::SRC_OSC_SLOW
			: counter_array_pkg::SRC_OSC_FAST)
		: (!source_sel_lo_reg ? counter_array_pkg::SRC_TIMER0
			: counter_array_pkg::SRC_EXTERNAL);
	assign osc_src = (source == counter_array_pkg::SRC_OSC_SLOW)
		| (source == counter_array_pkg::SRC_OSC_FAST);
	assign div_len = (source == counter_array_pkg::SRC_OSC_FAST)
		? (twelve_clock_mode ? `CA_DIV_FAST_12CLK : `CA_DIV_FAST_6CLK)
		: (twelve_clock_mode ? `CA_DIV_SLOW_12CLK : `CA_DIV_SLOW_6CLK);
	// A source change mid count must not leave the prescaler past its end.
	assign osc_tick   = (presc_reg >= div_len - 4'h1);
	assign presc_next = (osc_tick || !osc_src) ? 4'h0 : presc_reg + 4'h1;
	assign ext_fall   = ext_prev_reg & ~port1_in[`CA_P1_EXT_BIT];
	assign src_event  = (osc_src & osc_tick)
		| ((source == counter_array_pkg::SRC_TIMER0) & timer0_overflow)
		| ((source == counter_array_pkg::SRC_EXTERNAL) & ext_fall);
	assign halted     = idle_halt_reg & idle_mode;
	assign count_tick = counter_run_reg & ~halted & src_event;

	// Software writes to the counter bytes win over a count event.
	assign count_next = wr_cnt_lo ? {count_reg[15:8], sfr_wdata}
		: wr_cnt_hi ? {sfr_wdata, count_reg[7:0]}
		: count_tick ? count_reg + 16'h0001
		: count_reg;
	assign overflow = count_tick & ~cnt_wr & (count_reg == 16'hFFFF);

	// Hardware set wins over a software clear in the same cycle.
	assign ovf_next = overflow
		| (wr_ctrl ? sfr_wdata[`CA_CTRL_OVF] : overflow_flag_reg);
	assign ev_next  = ev_set
		| (wr_ctrl ? sfr_wdata[4:0] : module_event_flag_reg);
	assign irq_next = (overflow_flag_reg & overflow_irq_enable_reg)
		| (|(module_event_flag_reg & irq_en));
	assign wd_hit   = watchdog_enable_reg & mod_match[4];

	// Reserved control bit 5 and mode bits 5..3 read as zero.
	assign ctrl_rd = {overflow_flag_reg, counter_run_reg, 1'b0,
		module_event_flag_reg};
	assign mode_rd = {idle_halt_reg, watchdog_enable_reg, 3'b000,
		source_sel_hi_reg, source_sel_lo_reg, overflow_irq_enable_reg};
	assign base_rd = (sfr_addr == `CA_CTRL_ADDR) ? ctrl_rd
		: (sfr_addr == `CA_MODE_ADDR) ? mode_rd
		: (sfr_addr == `CA_CNT_LO_ADDR) ? count_reg[7:0]
		: (sfr_addr == `CA_CNT_HI_ADDR) ? count_reg[15:8]
		: 8'h00;
	assign rd_chain[0] = base_rd;
	assign rdata_next  = rd_chain[5];

	// Per-module instances and their read and pin wiring.
	genvar g;
	generate
		for (g = 0; g < 5; g++)
		begin : g_mod
			if (g < NUM_MODULES)
			begin : g_on
				logic                              hit_mode;
				logic                              hit_low;
				logic                              hit_high;
				counter_array_pkg::module_mode_t   mode;
				counter_array_pkg::count_t         value;
				logic [7:0]                        rd;

				assign hit_mode = (sfr_addr == `CA_MMODE_BASE + 8'(g));
				assign hit_low  = (sfr_addr == `CA_VLO_BASE + 8'(g));
				assign hit_high = (sfr_addr == `CA_VHI_BASE + 8'(g));
				assign rd = hit_mode ? {1'b0, mode}
					: hit_low ? value[7:0]
					: hit_high ? value[15:8]
					: 8'h00;
				assign rd_chain[g + 1] = rd_chain[g] | rd;
				assign irq_en[g] = mode[`CA_MM_IRQ_EN];

				capture_compare_unit u_unit
				(
					.clk         (clk),
					.rst_b       (rst_b),
					.mode_wr     (sfr_wr & hit_mode),
					.low_wr      (sfr_wr & hit_low),
					.high_wr     (sfr_wr & hit_high),
					.wdata       (sfr_wdata),
					.count       (count_reg),
					.count_moved (count_moved_reg),
					.pin_in      (port1_in[`CA_P1_MOD0_BIT + g]),
					.pin_out     (mod_pin_out[g]),
					.pin_oe      (mod_pin_oe[g]),
					.mode        (mode),
					.value       (value),
					.match       (mod_match[g]),
					.event_set   (ev_set[g])
				);
			end
			else
			begin : g_off
				assign rd_chain[g + 1] = rd_chain[g];
				assign irq_en[g]       = 1'b0;
				assign mod_match[g]    = 1'b0;
				assign ev_set[g]       = 1'b0;
				assign mod_pin_out[g]  = `CA_PIN_RST;
				assign mod_pin_oe[g]   = 1'b0;
			end
		end
	endgenerate

	// Module pins come from unit flip-flops, or CA_PIN_RST for absent modules; bits 2..0 are not driven.
	assign port1_out = {mod_pin_out, 3'b000};
	assign port1_oe  = {mod_pin_oe, 3'b000};

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			overflow_flag_reg       <= CTRL_RST[`CA_CTRL_OVF];
			counter_run_reg         <= 1'b0;
			module_event_flag_reg   <= 5'h00;
			idle_halt_reg           <= 1'b0;
			watchdog_enable_reg     <= 1'b0;
			source_sel_hi_reg       <= 1'b0;
			source_sel_lo_reg       <= 1'b0;
			overflow_irq_enable_reg <= 1'b0;
		end
		else
		begin
			overflow_flag_reg     <= ovf_next;
			module_event_flag_reg <= ev_next;
			if (wr_ctrl)
			begin
				counter_run_reg <= sfr_wdata[`CA_CTRL_RUN];
			end
			if (wr_mode)
			begin
				idle_halt_reg           <= sfr_wdata[`CA_MODE_IDLE];
				watchdog_enable_reg     <= sfr_wdata[`CA_MODE_WDT];
				source_sel_hi_reg       <= sfr_wdata[`CA_MODE_SRC_HI];
				source_sel_lo_reg       <= sfr_wdata[`CA_MODE_SRC_LO];
				overflow_irq_enable_reg <= sfr_wdata[`CA_MODE_OVF_IE];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			count_reg       <= 16'h0000;
			count_moved_reg <= 1'b0;
			presc_reg       <= 4'h0;
			ext_prev_reg    <= 1'b0;
			sfr_rdata       <= 8'h00;
			array_irq       <= 1'b0;
			watchdog_reset  <= 1'b0;
		end
		else
		begin
			count_reg       <= count_next;
			count_moved_reg <= count_tick & ~cnt_wr;
			presc_reg       <= presc_next;
			ext_prev_reg    <= port1_in[`CA_P1_EXT_BIT];
			sfr_rdata       <= sfr_rd ? rdata_next : sfr_rdata;
			array_irq       <= irq_next;
			watchdog_reset  <= wd_hit;
		end
	end

	sequence s_wrap;
		count_tick && !cnt_wr && (count_reg == 16'hFFFF);
	endsequence
	sequence s_wrapped;
		overflow_flag_reg && (count_reg == 16'h0000);
	endsequence

	property p_wrap_sets_flag;
		s_wrap |=> s_wrapped;
	endproperty
	a_wrap_sets_flag: assert property (p_wrap_sets_flag)
		else $error("rollover did not set overflow flag");

	property p_ovf_sticky;
		(overflow_flag_reg && !wr_ctrl) |=> overflow_flag_reg;
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky)
		else $error("overflow flag cleared without a write");

	property p_event_flag;
		(|ev_set) |=> ((module_event_flag_reg & $past(ev_set))
			== $past(ev_set));
	endproperty
	a_event_flag: assert property (p_event_flag)
		else $error("module event lost");

	property p_event_sticky;
		!wr_ctrl |=> ((module_event_flag_reg & $past(module_event_flag_reg))
			== $past(module_event_flag_reg));
	endproperty
	a_event_sticky: assert property (p_event_sticky)
		else $error("module flag cleared without a write");

	property p_step;
		(count_tick && !cnt_wr) |=> count_reg == $past(count_reg) + 16'h0001;
	endproperty
	a_step: assert property (p_step)
		else $error("counter did not step by one");

	property p_stopped;
		(!counter_run_reg && !cnt_wr) |=> $stable(count_reg);
	endproperty
	a_stopped: assert property (p_stopped)
		else $error("counter moved while stopped");

	property p_idle_halt;
		(idle_halt_reg && idle_mode && !cnt_wr) |=> $stable(count_reg);
	endproperty
	a_idle_halt: assert property (p_idle_halt)
		else $error("counter moved in idle with halt set");

	property p_irq;
		((overflow_flag_reg && overflow_irq_enable_reg)
			|| (|(module_event_flag_reg & irq_en))) |=> array_irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("enabled flag raised no interrupt");

	property p_no_irq;
		!(overflow_flag_reg && overflow_irq_enable_reg)
			&& !(|(module_event_flag_reg & irq_en)) |=> !array_irq;
	endproperty
	a_no_irq: assert property (p_no_irq)
		else $error("interrupt without enabled flag");

	property p_watchdog;
		wd_hit |=> watchdog_reset ##1 !watchdog_reset || $past(wd_hit, 1);
	endproperty
	a_watchdog: assert property (p_watchdog)
		else $error("watchdog hit gave no reset pulse");
endmodule

// File: design/counter_array_cfg.svh
// Register addresses, field positions, reset values and divider counts.
`ifndef COUNTER_ARRAY_CFG_SVH
`define COUNTER_ARRAY_CFG_SVH

`define CA_CTRL_ADDR      8'hC0
`define CA_MODE_ADDR      8'hC1
`define CA_CNT_LO_ADDR    8'hC2
`define CA_CNT_HI_ADDR    8'hC3
`define CA_MMODE_BASE     8'hC8
`define CA_VLO_BASE       8'hD0
`define CA_VHI_BASE       8'hD8

`define CA_CTRL_OVF       7
`define CA_CTRL_RUN       6
`define CA_MODE_IDLE      7
`define CA_MODE_WDT       6
`define CA_MODE_SRC_HI    2
`define CA_MODE_SRC_LO    1
`define CA_MODE_OVF_IE    0

`define CA_MM_IRQ_EN      0
`define CA_MM_PWM         1
`define CA_MM_FLIP        2
`define CA_MM_EQ_FLAG     3
`define CA_MM_FALL_CAP    4
`define CA_MM_RISE_CAP    5
`define CA_MM_CMP_EN      6

`define CA_CTRL_RST       8'h00
`define CA_MODE_RST       8'h00
`define CA_MM_RST         7'h00
`define CA_PIN_RST        1'b1

`define CA_DIV_SLOW_6CLK  4'h6
`define CA_DIV_SLOW_12CLK 4'hC
`define CA_DIV_FAST_6CLK  4'h2
`define CA_DIV_FAST_12CLK 4'h4

`define CA_P1_EXT_BIT     2
`define CA_P1_MOD0_BIT    3

`endif

// File: design/counter_array_pkg.sv
// Types shared by the counter array files.
package counter_array_pkg;
	typedef logic [15:0] count_t;
	typedef logic [6:0]  module_mode_t;
	typedef enum logic [3:0]
	{
		SRC_OSC_SLOW = 4'b0001,
		SRC_OSC_FAST = 4'b0010,
		SRC_TIMER0   = 4'b0100,
		SRC_EXTERNAL = 4'b1000
	} count_source_e;
endpackage

// File: design/capture_compare_unit.sv
// One capture/compare module of the counter array.
`timescale 1ns/1ps
`include "counter_array_cfg.svh"
module capture_compare_unit
(
	// Clock and reset.
	input  wire logic                          clk,
	input  wire logic                          rst_b,
	// Register writes.
	input  wire logic                          mode_wr,
	input  wire logic                          low_wr,
	input  wire logic                          high_wr,
	input  wire logic [7:0]                    wdata,
	// Shared time base.
	input  wire counter_array_pkg::count_t     count,
	input  wire logic                          count_moved,
	// Module pin.
	input  wire logic                          pin_in,
	output logic                               pin_out,
	output logic                               pin_oe,
	// State seen by the array.
	output counter_array_pkg::module_mode_t    mode,
	output counter_array_pkg::count_t          value,
	output logic                               match,
	output logic                               event_set
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic                       pin_prev_reg;
	logic                       cap_rise;
	logic                       cap_fall;
	logic                       capture;
	logic                       pwm_on;
	logic                       wrap;
	logic                       pwm_level;
	logic                       pin_next;
	counter_array_pkg::count_t  value_next;

	assign pwm_on   = mode[`CA_MM_PWM] & mode[`CA_MM_CMP_EN];
	assign cap_rise = mode[`CA_MM_RISE_CAP] & ~pin_prev_reg & pin_in;
	assign cap_fall = mode[`CA_MM_FALL_CAP] & pin_prev_reg & ~pin_in;
	assign capture  = cap_rise | cap_fall;
	// The compare is only taken right after the counter has moved.
	assign match    = mode[`CA_MM_CMP_EN] & ~pwm_on & count_moved
		& (count == value);
	assign event_set = (mode[`CA_MM_EQ_FLAG] & match) | capture;
	assign wrap      = pwm_on & count_moved & (count[7:0] == 8'h00);
	assign pwm_level = (count[7:0] >= value[7:0]);

	// Hardware capture wins over a software write in the same cycle.
	assign value_next = capture ? count
		: low_wr ? {value[15:8], wdata}
		: high_wr ? {wdata, value[7:0]}
		: wrap ? {value[15:8], value[15:8]}
		: value;
	assign pin_next = pwm_on ? pwm_level
		: (mode[`CA_MM_FLIP] & match) ? ~pin_out
		: pin_out;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode         <= `CA_MM_RST;
			value        <= 16'h0000;
			pin_prev_reg <= 1'b0;
			pin_out      <= `CA_PIN_RST;
			pin_oe       <= 1'b0;
		end
		else
		begin
			mode         <= mode_wr ? wdata[6:0] : mode;
			value        <= value_next;
			pin_prev_reg <= pin_in;
			pin_out      <= pin_next;
			pin_oe       <= pwm_on | mode[`CA_MM_FLIP];
		end
	end

	property p_capture_load;
		capture |=> value == $past(count);
	endproperty
	a_capture_load: assert property (p_capture_load)
		else $error("capture did not load the count");

	property p_pwm_level;
		pwm_on |=> pin_out == ($past(count[7:0]) >= $past(value[7:0]));
	endproperty
	a_pwm_level: assert property (p_pwm_level)
		else $error("pwm pin level wrong");

	property p_flip;
		(mode[`CA_MM_FLIP] && match) |=> pin_out != $past(pin_out);
	endproperty
	a_flip: assert property (p_flip)
		else $error("pin did not flip on equal");
endmodule

// File: test/port1_pins.sv
// Far-side model of the port 1 pins: count input and module pins.
`timescale 1ns/1ps
module port1_pins
(
	// Design side.
	input  wire logic [7:0] port1_out,
	input  wire logic [7:0] port1_oe,
	// Levels applied from outside.
	input  wire logic       ext_level,
	input  wire logic [4:0] mod_level,
	output logic      [7:0] port1_in
);
	// Lines nobody drives sit at their pull-up level.
	always_comb
	begin
		port1_in[1:0] = 2'h3;
		port1_in[2] = ext_level;
		for (int i = 0; i < 5; i++)
			port1_in[3 + i] = port1_oe[3 + i] ? port1_out[3 + i]
				: mod_level[i];
	end
endmodule

// File: test/testbench.sv
// Self-checking bench for the counter array.
`timescale 1ns/1ps
module testbench;
	logic        clk;
	logic        rst_b;
	logic [7:0]  sfr_addr;
	logic        sfr_wr;
	logic        sfr_rd;
	logic [7:0]  sfr_wdata;
	logic [7:0]  sfr_rdata;
	logic        twelve_clock_mode;
	logic        idle_mode;
	logic        timer0_overflow;
	logic [7:0]  port1_in;
	logic [7:0]  port1_out;
	logic [7:0]  port1_oe;
	logic        array_irq;
	logic        watchdog_reset;
	logic        ext_level;
	logic [4:0]  mod_level;
	logic [7:0]  rd;
	logic [15:0] v;
	logic [15:0] ex;
	logic [7:0]  m;
	int          n_fail = 0;
	int          n_compared = 0;
	int          n_wdt = 0;
	int          div [4] = '{6, 2, 12, 4};
	logic [7:0]  caps [5] = '{8'h20, 8'h10, 8'h30, 8'h20, 8'h10};

	counter_array #(.NUM_MODULES(5)) uut
	(
		.clk               (clk),
		.rst_b             (rst_b),
		.sfr_addr          (sfr_addr),
		.sfr_wr            (sfr_wr),
		.sfr_rd            (sfr_rd),
		.sfr_wdata         (sfr_wdata),
		.sfr_rdata         (sfr_rdata),
		.twelve_clock_mode (twelve_clock_mode),
		.idle_mode         (idle_mode),
		.timer0_overflow   (timer0_overflow),
		.port1_in          (port1_in),
		.port1_out         (port1_out),
		.port1_oe          (port1_oe),
		.array_irq         (array_irq),
		.watchdog_reset    (watchdog_reset)
	);

	port1_pins pins
	(
		.port1_out (port1_out),
		.port1_oe  (port1_oe),
		.ext_level (ext_level),
		.mod_level (mod_level),
		.port1_in  (port1_in)
	);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk)
		if (watchdog_reset === 1'b1)
			n_wdt <= n_wdt + 1;

	task automatic end_of_test();
		$display("Compared %0d, mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] e,
		input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask

	task automatic rdb(input logic [7:0] a);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		rd = sfr_rdata;
	endtask

	task automatic rd16(input logic [7:0] alo, input logic [7:0] ahi);
		rdb(alo);
		v[7:0] = rd;
		rdb(ahi);
		v[15:8] = rd;
	endtask

	// Loads the stopped counter with a 16-bit value.
	task automatic setcnt(input logic [15:0] c);
		wr(8'hC2, c[7:0]);
		wr(8'hC3, c[15:8]);
	endtask

	task automatic t0_pulses(input int k);
		repeat (k)
		begin
			@(negedge clk);
			timer0_overflow = 1'b1;
			@(negedge clk);
			timer0_overflow = 1'b0;
		end
		repeat (3) @(negedge clk);
	endtask

	task automatic wait_irq(input logic lvl);
		int i;
		for (i = 0; i < 200 && array_irq !== lvl; i++)
			@(negedge clk);
		chk("array_irq", lvl, array_irq);
		if (i == 200)
			end_of_test();
	endtask

	initial
	begin
		repeat (100000) @(posedge clk);
		n_fail++;
		end_of_test();
	end

	initial
	begin
		rst_b = 1'b0;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
		twelve_clock_mode = 1'b0;
		idle_mode = 1'b0;
		timer0_overflow = 1'b0;
		ext_level = 1'b1;
		mod_level = 5'h00;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		rdb(8'hC0);
		chk("control", 16'h0000, rd);
		chk("port1_out", 16'h00F8, port1_out);
		chk("port1_oe", 16'h0000, port1_oe);
		rdb(8'hA0);
		chk("unmapped", 16'h0000, rd);
		wr(8'hC0, 8'h1F);
		rdb(8'hC0);
		chk("sw set module flags", 16'h001F, rd);
		wr(8'hC0, 8'h80);
		rdb(8'hC0);
		chk("sw set flag", 16'h0080, rd);
		wr(8'hC0, 8'h00);
		rdb(8'hC0);
		chk("sw clear flag", 16'h0000, rd);
		// Overflow from FFFE with the fast source and interrupt enabled.
		wr(8'hC1, 8'h03);
		setcnt(16'hFFFE);
		wr(8'hC0, 8'h40);
		wait_irq(1'b1);
		wr(8'hC0, 8'h80);
		repeat (20) @(negedge clk);
		rdb(8'hC0);
		chk("flag held", 16'h0080, rd);
		wr(8'hC0, 8'h00);
		wait_irq(1'b0);
		wr(8'hC1, 8'h02);
		wr(8'hC0, 8'h80);
		repeat (3) @(negedge clk);
		chk("irq masked", 16'h0000, array_irq);
		wr(8'hC0, 8'h00);
		setcnt(16'h1234);
		repeat (20) @(negedge clk);
		rd16(8'hC2, 8'hC3);
		chk("count stopped", 16'h1234, v);
		// Oscillator sources in both clock modes.
		for (int s = 0; s < 4; s++)
		begin
			twelve_clock_mode = s[1];
			wr(8'hC1, {6'h00, s[0], 1'b0});
			setcnt(16'h0000);
			wr(8'hC0, 8'h40);
			repeat (60) @(negedge clk);
			wr(8'hC0, 8'h00);
			rdb(8'hC2);
			chk("divided count", 16'h0001, 16'(rd >= 60 / div[s]
				&& rd <= 60 / div[s] + 1));
		end
		twelve_clock_mode = 1'b0;
		// Timer 0 source with idle halt.
		wr(8'hC1, 8'h04);
		setcnt(16'hFFFF);
		wr(8'hC0, 8'h40);
		t0_pulses(3);
		wr(8'hC1, 8'h84);
		idle_mode = 1'b1;
		t0_pulses(2);
		idle_mode = 1'b0;
		t0_pulses(1);
		wr(8'hC0, 8'h80);
		rd16(8'hC2, 8'hC3);
		chk("timer0 count", 16'h0003, v);
		rdb(8'hC0);
		chk("wrap flag", 16'h0080, rd);
		// External count input on falling edges.
		wr(8'hC1, 8'h06);
		setcnt(16'h0000);
		wr(8'hC0, 8'h40);
		repeat (3)
		begin
			@(negedge clk);
			ext_level = 1'b0;
			repeat (3) @(negedge clk);
			ext_level = 1'b1;
			repeat (3) @(negedge clk);
		end
		wr(8'hC0, 8'h00);
		rd16(8'hC2, 8'hC3);
		chk("ext count", 16'h0003, v);
		// Capture on each module pin with every edge selection.
		for (int n = 0; n < 5; n++)
		begin
			m = caps[n];
			setcnt({8'hA0, 8'(n)});
			wr(8'hC8 + 8'(n), m);
			@(negedge clk);
			mod_level[n] = 1'b1;
			repeat (3) @(negedge clk);
			ex = m[5] ? {8'hA0, 8'(n)} : 16'h0000;
			rd16(8'hD0 + 8'(n), 8'hD8 + 8'(n));
			chk("rise capture", ex, v);
			rdb(8'hC0);
			chk("capture flag", 16'(m[5]) << n, rd);
			wr(8'hC0, 8'h00);
			setcnt({8'hB0, 8'(n)});
			mod_level[n] = 1'b0;
			repeat (3) @(negedge clk);
			ex = m[4] ? {8'hB0, 8'(n)} : ex;
			rd16(8'hD0 + 8'(n), 8'hD8 + 8'(n));
			chk("fall capture", ex, v);
			wr(8'hC0, 8'h00);
			wr(8'hC8 + 8'(n), 8'h00);
		end
		// Equal without the comparator, then with it.
		wr(8'hC1, 8'h04);
		wr(8'hD1, 8'h02);
		wr(8'hD9, 8'h00);
		wr(8'hC9, 8'h08);
		setcnt(16'h0000);
		wr(8'hC0, 8'h40);
		t0_pulses(3);
		rdb(8'hC0);
		chk("no comparator", 16'h0040, rd);
		wr(8'hC0, 8'h00);
		wr(8'hC9, 8'h49);
		setcnt(16'h0000);
		wr(8'hC0, 8'h40);
		t0_pulses(3);
		rdb(8'hC0);
		chk("match flag", 16'h0042, rd);
		wait_irq(1'b1);
		wr(8'hC9, 8'h48);
		wait_irq(1'b0);
		wr(8'hC0, 8'h00);
		wr(8'hC9, 8'h00);
		// Flip on equal on module 2, watchdog on module 4.
		wr(8'hD2, 8'h05);
		wr(8'hDA, 8'h00);
		wr(8'hCA, 8'h44);
		wr(8'hD4, 8'h05);
		wr(8'hDC, 8'h00);
		wr(8'hCC, 8'h48);
		wr(8'hC1, 8'h44);
		chk("flip drive", 16'h0001, port1_oe[5]);
		setcnt(16'h0000);
		wr(8'hC0, 8'h40);
		t0_pulses(6);
		wr(8'hC0, 8'h50);
		chk("flip pin", 16'h0000, port1_out[5]);
		chk("watchdog pulses", 16'h0001, 16'(n_wdt));
		rdb(8'hC0);
		chk("module 4 flag", 16'h0050, rd);
		wr(8'hC0, 8'h00);
		// Pulse width output on module 3 against the low count byte.
		wr(8'hD3, 8'h80);
		wr(8'hDB, 8'h80);
		wr(8'hCB, 8'h42);
		setcnt(16'h0010);
		repeat (2) @(negedge clk);
		chk("pwm drive", 16'h0001, port1_oe[6]);
		chk("pwm below", 16'h0000, port1_out[6]);
		setcnt(16'h0090);
		repeat (2) @(negedge clk);
		chk("pwm above", 16'h0001, port1_out[6]);
		// Low byte wrap reloads the duty byte from the high byte.
		wr(8'hDB, 8'h20);
		setcnt(16'h00FF);
		wr(8'hC0, 8'h40);
		t0_pulses(1);
		wr(8'hC0, 8'h00);
		rdb(8'hD3);
		chk("pwm reload", 16'h0020, rd);
		chk("pwm after reload", 16'h0000, port1_out[6]);
		end_of_test();
	end
endmodule
